// *** gpc_cfg.svh ***
`ifndef GPC_CFG_SVH
`define GPC_CFG_SVH

////////////////////////////////////////////////////////////////////////////////
// Register map
`define GPC_PIN_CTRL_OFF   8'hB8

////////////////////////////////////////////////////////////////////////////////
// Per-pin field layout, slice of four bits at 4n
`define GPC_PINS           8
`define GPC_SLICE_W        4
`define GPC_FLD_IN         0
`define GPC_FLD_DIR        1
`define GPC_FLD_OUT        2
`define GPC_FLD_RSVD       3

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define GPC_DIR_RST        8'h00
`define GPC_OUT_RST        8'h00
`define GPC_RSVD_MASK      32'h88888888

`endif

// *** gpc_pkg.sv ***
package gpc_pkg;

    typedef enum logic [1:0] {
        GPC_OKAY   = 2'h0,
        GPC_SLVERR = 2'h2,
        GPC_DECERR = 2'h3
    } gpc_resp_type;

endpackage : gpc_pkg

// *** gpc_top.sv ***
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ns
`include "gpc_cfg.svh"

// Function
// R1 - The pin control word sits at byte offset B8h and exists only when the block is the upstream port.
// R2 - Pin n owns bits 4n to 4n+3 as input, direction, output value and a reserved bit that is left alone.
// R3 - The input bit is read-only and returns the sampled pin level in either direction.
// R4 - A direction bit of 0 makes the pin an input and 1 makes it an output.
// R5 - An output pin is driven with its output value bit.
// R6 - Reset clears all direction and output value bits, so every pin starts as an input.
// R7 - An input pin is not driven; its driver is released.

module gpc_top #(
    parameter int          ADDR_W   = 8,
    parameter bit          UPSTREAM = 1'b1
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic [7:0]        gpio_in,
    output logic [7:0]             gpio_out,
    output logic [7:0]             gpio_oe_n
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [7:0]        in_s1_r;
    logic [7:0]        in_s2_r;
    logic [7:0]        out_r;
    logic [7:0]        oe_n_r;
    logic              awready_r;
    logic              wready_r;
    logic              bvalid_r;
    logic [1:0]        bresp_r;
    logic              arready_r;
    logic              rvalid_r;
    logic [1:0]        rresp_r;
    logic [31:0]       rdata_r;
    logic              aw_got_r;
    logic              w_got_r;
    logic [ADDR_W-1:0] awaddr_r;
    logic [31:0]       wdata_r;
    logic [3:0]        wstrb_r;
    logic              aw_hs;
    logic              w_hs;
    logic              ar_hs;
    logic              do_write;
    logic              wr_hit;
    logic              rd_hit;
    logic              aw_got_nxt;
    logic              w_got_nxt;
    logic              bvalid_nxt;
    logic              rvalid_nxt;
    logic [31:0]       rd_word;

    localparam logic [7:0] DIR_RST = `GPC_DIR_RST;
    localparam logic [7:0] OUT_RST = `GPC_OUT_RST;

    assign s_axi_awready = awready_r;
    assign s_axi_wready  = wready_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rresp   = rresp_r;
    assign s_axi_rdata   = rdata_r;
    assign gpio_out      = out_r;
    assign gpio_oe_n     = oe_n_r;

    ////////////////////////////////////////////////////////////////////////////
    // Pin input synchroniser
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            in_s1_r <= 8'h00;
            in_s2_r <= 8'h00;
        end else begin
            in_s1_r <= gpio_in;
            in_s2_r <= in_s1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Address decode
    assign wr_hit = UPSTREAM &&
        (awaddr_r[ADDR_W-1:2] == (ADDR_W-2)'(`GPC_PIN_CTRL_OFF >> 2)); // R1
    assign rd_hit = UPSTREAM &&
        (s_axi_araddr[ADDR_W-1:2] == (ADDR_W-2)'(`GPC_PIN_CTRL_OFF >> 2)); // R1

    ////////////////////////////////////////////////////////////////////////////
    // Write channels
    assign aw_hs      = s_axi_awvalid && awready_r;
    assign w_hs       = s_axi_wvalid && wready_r;
    assign do_write   = aw_got_r && w_got_r && !bvalid_r;
    assign aw_got_nxt = aw_hs || (aw_got_r && !do_write);
    assign w_got_nxt  = w_hs || (w_got_r && !do_write);
    assign bvalid_nxt = do_write || (bvalid_r && !s_axi_bready);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_r  <= 1'b0;
            w_got_r   <= 1'b0;
            awready_r <= 1'b0;
            wready_r  <= 1'b0;
        end else begin
            aw_got_r  <= aw_got_nxt;
            w_got_r   <= w_got_nxt;
            awready_r <= !aw_got_nxt && !bvalid_nxt;
            wready_r  <= !w_got_nxt && !bvalid_nxt;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awaddr_r <= '0;
        end else if (aw_hs) begin
            awaddr_r <= s_axi_awaddr;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
        end else if (w_hs) begin
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r  <= gpc_pkg::GPC_OKAY;
        end else begin
            bvalid_r <= bvalid_nxt;
            if (do_write) begin
                bresp_r <= wr_hit ? gpc_pkg::GPC_OKAY : gpc_pkg::GPC_DECERR; // R1
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin control bits, one slice per pin
    genvar n;
    generate
        for (n = 0; n < `GPC_PINS; n = n + 1) begin : g_pin
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    oe_n_r[n] <= ~DIR_RST[n]; // R6 R7
                    out_r[n]  <= OUT_RST[n]; // R6
                end else if (do_write && wr_hit && wstrb_r[n/2]) begin
                    oe_n_r[n] <= !wdata_r[`GPC_SLICE_W*n+`GPC_FLD_DIR]; // R4 R7
                    out_r[n]  <= wdata_r[`GPC_SLICE_W*n+`GPC_FLD_OUT]; // R5
                end
            end
            assign rd_word[`GPC_SLICE_W*n+`GPC_FLD_IN]   = in_s2_r[n]; // R3
            assign rd_word[`GPC_SLICE_W*n+`GPC_FLD_DIR]  = !oe_n_r[n]; // R2
            assign rd_word[`GPC_SLICE_W*n+`GPC_FLD_OUT]  = out_r[n]; // R2
            assign rd_word[`GPC_SLICE_W*n+`GPC_FLD_RSVD] = 1'b0; // R2
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Read channel
    assign ar_hs      = s_axi_arvalid && arready_r;
    assign rvalid_nxt = ar_hs || (rvalid_r && !s_axi_rready);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b0;
        end else begin
            arready_r <= !rvalid_nxt;
            rvalid_r  <= rvalid_nxt;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rdata_r <= 32'h00000000;
            rresp_r <= gpc_pkg::GPC_OKAY;
        end else if (ar_hs) begin
            rdata_r <= rd_hit ? rd_word : 32'h00000000; // R1 R3
            rresp_r <= rd_hit ? gpc_pkg::GPC_OKAY : gpc_pkg::GPC_DECERR; // R1
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    a_unmapped_read: assert property (@(posedge aclk) disable iff (!aresetn) // R1
        ar_hs && !rd_hit |=> rresp_r == gpc_pkg::GPC_DECERR && rdata_r == 32'h00000000)
        else $error("unmapped read not refused");

    a_rsvd_reads_zero: assert property (@(posedge aclk) disable iff (!aresetn) // R2
        rvalid_r |-> (rdata_r & `GPC_RSVD_MASK) == 32'h00000000)
        else $error("reserved bit read nonzero");

    a_input_sampled: assert property (@(posedge aclk) disable iff (!aresetn) // R3
        ar_hs && rd_hit |=> rdata_r[`GPC_FLD_IN] == $past(in_s2_r[0]))
        else $error("input bit not the sampled pin");

    a_dir_write_oe: assert property (@(posedge aclk) disable iff (!aresetn) // R4
        do_write && wr_hit && wstrb_r[0] |=> gpio_oe_n[0] == !$past(wdata_r[`GPC_FLD_DIR]))
        else $error("direction write not applied");

    a_out_write_pin: assert property (@(posedge aclk) disable iff (!aresetn) // R5
        do_write && wr_hit && wstrb_r[3] |=> gpio_out[7] == $past(wdata_r[30]))
        else $error("output value not driven");

    a_reset_inputs: assert property (@(posedge aclk) disable iff (1'b0) // R6
        !aresetn |=> gpio_oe_n == 8'hFF && gpio_out == 8'h00)
        else $error("pins not inputs after reset");

    a_input_released: assert property (@(posedge aclk) disable iff (!aresetn) // R7
        ar_hs && rd_hit |=> rdata_r[`GPC_FLD_DIR] == !gpio_oe_n[0])
        else $error("driver state differs from direction");

    a_bresp_holds: assert property (@(posedge aclk) disable iff (!aresetn)
        bvalid_r && !s_axi_bready |=> bvalid_r && $stable(bresp_r))
        else $error("write response dropped");

endmodule : gpc_top

// *** gpc_board.sv ***
`timescale 1ns/1ns

// Board side of the eight pins: a pin driven by the block shows its value,
// a released pin shows the level the board puts on it
module gpc_board (
    input  wire logic [7:0] gpio_out,
    input  wire logic [7:0] gpio_oe_n,
    input  wire logic [7:0] ext_lvl,
    output logic      [7:0] gpio_in
);
    always_comb gpio_in = (gpio_out & ~gpio_oe_n) | (ext_lvl & gpio_oe_n);
endmodule : gpc_board

// *** tb_top.sv ***
`timescale 1ns/1ns
`include "gpc_cfg.svh"

module tb_top;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [7:0]  awaddr = '0, araddr = '0, ext_lvl = '0, gpio_in, gpio_out, gpio_oe_n;
    logic [31:0] wdata = '0, rdata;
    logic [3:0]  wstrb = '0;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [7:0]  md = '0, mo = '0;
    int          errors = 0, total_checks = 0, cyc = 0;

    gpc_top i_gpc_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .gpio_in(gpio_in),
        .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n));
    gpc_board i_gpc_board (.gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n), .ext_lvl(ext_lvl), .gpio_in(gpio_in));

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #5 aclk = ~aclk;
    end

    always @(posedge aclk) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("Checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : results

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
        logic aw_p, w_p;
        aw_p = 1;
        w_p = 1;
        awaddr <= a; wdata <= d; wstrb <= s; awvalid <= 1; wvalid <= 1; bready <= 1;
        while (aw_p || w_p) begin
            @(posedge aclk);
            if (aw_p && awready) begin aw_p = 0; awvalid <= 0; end
            if (w_p && wready) begin w_p = 0; wvalid <= 0; end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a; arvalid <= 1; rready <= 1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 0;
    endtask : rd

    function automatic logic [31:0] word();
        logic [31:0] w;
        w = '0;
        for (int n = 0; n < 8; n++) begin
            w[4*n]   = md[n] ? mo[n] : ext_lvl[n];
            w[4*n+1] = md[n];
            w[4*n+2] = mo[n];
        end
        return w;
    endfunction : word

    task automatic verify();
        logic [31:0] v;
        logic [1:0]  r;
        repeat (3) @(posedge aclk);
        rd(`GPC_PIN_CTRL_OFF, v, r);
        chk("rresp", gpc_pkg::GPC_OKAY, r);
        chk("pin word", word(), v);
        chk("gpio_oe_n", {24'h000000, ~md}, gpio_oe_n);
        chk("gpio_out", mo, gpio_out);
        $display("Test done, checks %0d", total_checks);
    endtask : verify

    task automatic wcase(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
        logic [1:0] r;
        wr(a, v, s, r);
        chk("bresp", (a == `GPC_PIN_CTRL_OFF) ? gpc_pkg::GPC_OKAY : gpc_pkg::GPC_DECERR, r);
        if (a == `GPC_PIN_CTRL_OFF)
            for (int k = 0; k < 8; k++)
                if (s[k/2]) begin
                    md[k] = v[4*k+1];
                    mo[k] = v[4*k+2];
                end
        verify();
    endtask : wcase

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] v;
        logic [1:0]  r;
        ext_lvl = 8'hA5;
        repeat (4) @(posedge aclk);
        aresetn <= 1;
        verify();
        wcase(`GPC_PIN_CTRL_OFF, 32'hFFFFFFFF, 4'hF);
        @(posedge aclk) ext_lvl <= 8'h5A;
        wcase(`GPC_PIN_CTRL_OFF, 32'h40624062, 4'hF);
        wcase(`GPC_PIN_CTRL_OFF, 32'h00000000, 4'h2);
        wcase(8'hBC, 32'hFFFFFFFF, 4'hF);
        @(posedge aclk);
        rd(8'h9C, v, r);
        chk("unmapped rresp", gpc_pkg::GPC_DECERR, r);
        chk("unmapped rdata", 32'h00000000, v);
        @(posedge aclk) aresetn <= 0;
        repeat (4) @(posedge aclk);
        aresetn <= 1;
        md = '0;
        mo = '0;
        verify();
        results();
    end
endmodule : tb_top
